// ==== hw/grc_top.v ====
/*
  generator run control: mode decisions, quiet window, changeover delay, exercise run,
  run timer and an ahb-lite register slave.
  assumes: batt_volt (tenths of a volt), tod_hour and minute_tick come from logic on hclk;
  minute_tick is one cycle per minute; the relay outputs drive the terminal switches.
*/
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "grc_map.vh"

module grc_top
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [7:0] batt_volt,
  input wire [4:0] tod_hour,
  input wire minute_tick,
  output reg load_term_drive,
  output reg gp_term_drive,
  output reg gen_run_indicator
);

// ==========================================================
// helpers
function in_rng;
  input [7:0] v;
  input [7:0] lo;
  input [7:0] hi;
  begin
    in_rng = (v >= lo) && (v <= hi);
  end
endfunction

// ==========================================================
// declarations
reg wr_pend_r, start_crit, stop_crit;
reg [1:0] load_output_config_r, gp_output_config_r, state_r, state_nxt;
reg [2:0] gen_mode_select_r, program_select_r;
reg [3:0] changeover_delay_min_r;
reg [4:0] hour_prev_r;
reg [5:0] run_duration_hours_r;
reg [7:0] wr_addr_r, start_v_r, stop_v_r, start_pct_r, stop_pct_r, exercise_interval_days_r;
reg [7:0] days_since_exercise_r, run_elapsed_time_r, soc_r;
reg [31:0] rd_val;
wire acc, wr_en, quiet_now, quiet_block, gen_manual_toggle, soc_reset, nine_evt, exer_go, expire, running;
wire v_low, v_high, start_flt_en, stop_flt_en, start_done, stop_done;
wire [2:0] eff_mode, base_mode;
wire [7:0] wd8, days_inc, dur_min;

// ==========================================================
// ahb-lite slave: zero wait states, always okay
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign acc = hsel && htrans[1] && hready;
assign wr_en = wr_pend_r;
assign wd8 = hwdata[7:0];

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_pend_r <= 1'b0;
    wr_addr_r <= 8'h00;
  end
  else
  begin
    wr_pend_r <= acc && hwrite;
    if (acc)
      wr_addr_r <= haddr[7:0];
  end
end

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
    hrdata <= 32'h0000_0000;
  else if (acc && !hwrite)
    hrdata <= rd_val;
end

always @*
begin
  rd_val = 32'h0000_0000;
  case (haddr[7:0])
    `GRC_A_CTRL:
    begin
      rd_val[`GRC_F_MODE] = gen_mode_select_r;
      rd_val[`GRC_F_PROGRAM_SELECT] = program_select_r;
      rd_val[`GRC_F_LCFG] = load_output_config_r;
      rd_val[`GRC_F_GCFG] = gp_output_config_r;
    end
    `GRC_A_START_V: rd_val[7:0] = start_v_r;
    `GRC_A_STOP_V: rd_val[7:0] = stop_v_r;
    `GRC_A_START_PCT: rd_val[7:0] = start_pct_r;
    `GRC_A_STOP_PCT: rd_val[7:0] = stop_pct_r;
    `GRC_A_DELAY: rd_val[3:0] = changeover_delay_min_r;
    `GRC_A_RUN_DUR: rd_val[5:0] = run_duration_hours_r;
    `GRC_A_EXER_INT: rd_val[7:0] = exercise_interval_days_r;
    `GRC_A_DAYS: rd_val[7:0] = days_since_exercise_r;
    `GRC_A_ELAPSED: rd_val[7:0] = run_elapsed_time_r;
    `GRC_A_SOC: rd_val[7:0] = soc_r;
    `GRC_A_STATUS:
    begin
      rd_val[`GRC_F_ST_RUN] = running;
      rd_val[`GRC_F_ST_STATE] = state_r;
      rd_val[`GRC_F_ST_QUIET] = quiet_now;
    end
    default: rd_val = 32'h0000_0000;
  endcase
end

// ==========================================================
// setting registers with range checks, except start voltage and terminal configs
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    gen_mode_select_r <= 3'h0;
    program_select_r <= 3'h0;
    load_output_config_r <= 2'h0;
    gp_output_config_r <= 2'h0;
    start_v_r <= `GRC_R_START_V;
    stop_v_r <= `GRC_R_STOP_V;
    start_pct_r <= `GRC_R_START_PCT;
    stop_pct_r <= `GRC_R_STOP_PCT;
    changeover_delay_min_r <= `GRC_R_DELAY;
    run_duration_hours_r <= `GRC_R_RUN_DUR;
    exercise_interval_days_r <= `GRC_R_EXER_INT;
  end
  else if (wr_en)
  begin
    case (wr_addr_r)
      `GRC_A_CTRL:
      begin
        if (program_select_r == `GRC_PROGRAM_SELECT_USER && hwdata[`GRC_F_MODE] <= `GRC_MODE_MAX)
          gen_mode_select_r <= hwdata[`GRC_F_MODE];
        if (hwdata[`GRC_F_PROGRAM_SELECT] <= `GRC_PROGRAM_SELECT_USER)
          program_select_r <= hwdata[`GRC_F_PROGRAM_SELECT];
        load_output_config_r <= hwdata[`GRC_F_LCFG];
        gp_output_config_r <= hwdata[`GRC_F_GCFG];
      end
      `GRC_A_START_V:
        start_v_r <= wd8;
      `GRC_A_STOP_V:
        if (in_rng(wd8, `GRC_STOPV_LO, `GRC_STOPV_HI))
          stop_v_r <= wd8;
      `GRC_A_START_PCT:
        if (in_rng(wd8, `GRC_STARTP_LO, `GRC_STARTP_HI))
          start_pct_r <= wd8;
      `GRC_A_STOP_PCT:
        if (in_rng(wd8, `GRC_STOPP_LO, `GRC_STOPP_HI))
          stop_pct_r <= wd8;
      `GRC_A_DELAY:
        if (in_rng(wd8, `GRC_DELAY_LO, `GRC_DELAY_HI))
          changeover_delay_min_r <= wd8[3:0];
      `GRC_A_RUN_DUR:
        if (wd8 <= `GRC_DUR_HI)
          run_duration_hours_r <= wd8[5:0];
      `GRC_A_EXER_INT:
        if (in_rng(wd8, `GRC_EXI_LO, `GRC_EXI_HI))
          exercise_interval_days_r <= wd8;
      default: ;
    endcase
  end
end

// ==========================================================
// commands and charge level
assign gen_manual_toggle = wr_en && (wr_addr_r == `GRC_A_CMD) && hwdata[`GRC_F_CMD_TOG];
assign soc_reset = wr_en && (wr_addr_r == `GRC_A_CMD) && hwdata[`GRC_F_CMD_SOC];

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
    soc_r <= `GRC_R_SOC;
  else if (soc_reset)
    soc_r <= `GRC_R_SOC;
  else if (wr_en && wr_addr_r == `GRC_A_SOC && wd8 <= `GRC_SOC_HI)
    soc_r <= wd8;
end

// ==========================================================
// mode decode and quiet window
assign eff_mode = (program_select_r < `GRC_PROGRAM_SELECT_USER) ? `GRC_MODE_VOLT : gen_mode_select_r;
assign base_mode = (eff_mode >= `GRC_MODE_NQ) ? eff_mode - `GRC_MODE_NQ : eff_mode;
assign quiet_now = (tod_hour >= `GRC_HR_EVENING) || (tod_hour < `GRC_HR_MORNING);
assign quiet_block = quiet_now && (eff_mode <= `GRC_MODE_QMAX);

// ==========================================================
// start and stop criteria
assign v_low = batt_volt <= start_v_r;
assign v_high = batt_volt >= stop_v_r;
assign start_flt_en = (state_r == `GRC_S_IDLE) && (base_mode == `GRC_MODE_VOLT);
assign stop_flt_en = (state_r == `GRC_S_AUTO || state_r == `GRC_S_MAN) && (base_mode <= `GRC_MODE_MIX);

grc_dly u_start_dly
(
  .hclk(hclk),
  .hresetn(hresetn),
  .enable(start_flt_en),
  .cond(v_low),
  .minute_tick(minute_tick),
  .delay_min(changeover_delay_min_r),
  .done(start_done)
);

grc_dly u_stop_dly
(
  .hclk(hclk),
  .hresetn(hresetn),
  .enable(stop_flt_en),
  .cond(v_high),
  .minute_tick(minute_tick),
  .delay_min(changeover_delay_min_r),
  .done(stop_done)
);

always @*
begin
  start_crit = 1'b0;
  stop_crit = 1'b0;
  case (base_mode)
    `GRC_MODE_VOLT:
    begin
      start_crit = start_done;
      stop_crit = stop_done;
    end
    `GRC_MODE_MIX:
    begin
      start_crit = soc_r <= start_pct_r;
      stop_crit = stop_done;
    end
    `GRC_MODE_SOC:
    begin
      start_crit = soc_r <= start_pct_r;
      stop_crit = soc_r >= stop_pct_r;
    end
    default:
      start_crit = 1'b0;
  endcase
end

// ==========================================================
// exercise scheduling and day counter
assign nine_evt = (tod_hour == `GRC_HR_MORNING) && (hour_prev_r != `GRC_HR_MORNING);
assign days_inc = (days_since_exercise_r == `GRC_CNT_MAX) ? `GRC_CNT_MAX : days_since_exercise_r + 8'h01;
assign exer_go = nine_evt && (eff_mode != `GRC_MODE_MAN) && (days_inc >= exercise_interval_days_r)
  && (state_r != `GRC_S_EXER);

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    hour_prev_r <= `GRC_HR_MORNING;
    days_since_exercise_r <= 8'h00;
  end
  else
  begin
    hour_prev_r <= tod_hour;
    if (wr_en && wr_addr_r == `GRC_A_DAYS)
      days_since_exercise_r <= wd8;
    else if (exer_go)
      days_since_exercise_r <= 8'h00;
    else if (nine_evt)
      days_since_exercise_r <= days_inc;
  end
end

// ==========================================================
// run timer in minutes
assign running = state_r != `GRC_S_IDLE;
assign dur_min = {2'h0, run_duration_hours_r} * `GRC_MIN_PER_TENTH;
assign expire = run_elapsed_time_r >= dur_min;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
    run_elapsed_time_r <= 8'h00;
  else if (wr_en && wr_addr_r == `GRC_A_ELAPSED)
    run_elapsed_time_r <= wd8;
  else if (state_nxt == `GRC_S_IDLE || state_nxt != state_r)
    run_elapsed_time_r <= 8'h00;
  else if (minute_tick && running && run_elapsed_time_r != `GRC_CNT_MAX)
    run_elapsed_time_r <= run_elapsed_time_r + 8'h01;
end

// ==========================================================
// run state machine
always @*
begin
  state_nxt = state_r;
  case (state_r)
    `GRC_S_IDLE:
    begin
      if (exer_go)
        state_nxt = `GRC_S_EXER;
      else if (gen_manual_toggle && !quiet_now)
        state_nxt = `GRC_S_MAN;
      else if (start_crit && !quiet_block)
        state_nxt = `GRC_S_AUTO;
    end
    `GRC_S_AUTO:
    begin
      if (exer_go)
        state_nxt = `GRC_S_EXER;
      else if (gen_manual_toggle && !quiet_now)
        state_nxt = `GRC_S_IDLE;
      else if (stop_crit || quiet_block || base_mode == `GRC_MODE_MAN)
        state_nxt = `GRC_S_IDLE;
    end
    `GRC_S_MAN:
    begin
      if (exer_go)
        state_nxt = `GRC_S_EXER;
      else if (gen_manual_toggle && !quiet_now)
        state_nxt = `GRC_S_IDLE;
      else if (base_mode == `GRC_MODE_MAN && expire)
        state_nxt = `GRC_S_IDLE;
      else if (stop_crit || quiet_block)
        state_nxt = `GRC_S_IDLE;
    end
    `GRC_S_EXER:
      if (expire)
        state_nxt = `GRC_S_IDLE;
    default:
      state_nxt = `GRC_S_IDLE;
  endcase
end

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
    state_r <= `GRC_S_IDLE;
  else
    state_r <= state_nxt;
end

// ==========================================================
// run level to the relay terminals and the indicator
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    load_term_drive <= 1'b0;
    gp_term_drive <= 1'b0;
    gen_run_indicator <= 1'b0;
  end
  else
  begin
    load_term_drive <= running && (load_output_config_r == `GRC_CFG_GEN);
    gp_term_drive <= running && (gp_output_config_r == `GRC_CFG_GEN);
    gen_run_indicator <= running;
  end
end

endmodule // grc_top

// ==== hw/grc_map.vh ====
/*
  register map, field positions, reset values and limits of the generator run control block.
  assumes: included by grc_top.v and grc_dly.v by bare name; definitions only.
*/
// Contract
// - generator mode 0 to 6 accepted; its start and stop criteria apply
// - modes 0, 1, 2 hold request off from 9pm until 9am
// - modes 4, 5, 6 copy modes 0, 1, 2 without quiet window
// - voltage mode: start/stop after voltage holds past threshold for changeover delay
// - mixed mode: start on charge level, stop on voltage held for delay
// - charge mode: start when level falls to start, stop at stop level
// - mode 3 manual start runs generator for run duration in tenths of an hour (6 minutes each), then releases
// - voltage stop threshold accepted only within 11.0 to 16.5 volts
// - charge-level start threshold accepted only within 0 to 99 percent
// - charge-level stop threshold accepted only within 1 to 125 percent
// - charge level held up to 127 percent; command resets it to 100
// - changeover delay in whole minutes filters transients; default ten minutes
// - exercise run starts at 9am once interval days have elapsed
// - days since last exercise counted and readable
// - exercise lasts run duration; elapsed run time counted and readable
// - operator may overwrite days counter and elapsed run time counter
// - no automatic exercise in manual mode 3
// - manual toggle ignored while exercise run active
// - programs 0 to 3 force mode 0; only program 4 allows changes
// - relay driven from load or general terminal whose config equals 2
// - manual toggle flips request; refused between 9pm and 9am
// - indicator shows whenever the block requests the generator run
// - only a run or stop level goes out; no cranking sequence
`ifndef GRC_MAP_VH
`define GRC_MAP_VH

// register byte offsets
`define GRC_A_CTRL 8'h00
`define GRC_A_START_V 8'h04
`define GRC_A_STOP_V 8'h08
`define GRC_A_START_PCT 8'h0c
`define GRC_A_STOP_PCT 8'h10
`define GRC_A_DELAY 8'h14
`define GRC_A_RUN_DUR 8'h18
`define GRC_A_EXER_INT 8'h1c
`define GRC_A_DAYS 8'h20
`define GRC_A_ELAPSED 8'h24
`define GRC_A_SOC 8'h28
`define GRC_A_CMD 8'h2c
`define GRC_A_STATUS 8'h30

// control fields
`define GRC_F_MODE 2:0
`define GRC_F_PROGRAM_SELECT 6:4
`define GRC_F_LCFG 9:8
`define GRC_F_GCFG 11:10
`define GRC_F_CMD_TOG 0
`define GRC_F_CMD_SOC 1
`define GRC_F_ST_RUN 0
`define GRC_F_ST_STATE 2:1
`define GRC_F_ST_QUIET 3

// reset values
`define GRC_R_START_V 8'h76
`define GRC_R_STOP_V 8'h8c
`define GRC_R_START_PCT 8'h32
`define GRC_R_STOP_PCT 8'h5f
`define GRC_R_DELAY 4'ha
`define GRC_R_RUN_DUR 6'h0a
`define GRC_R_EXER_INT 8'h07
`define GRC_R_SOC 8'h64

// limits
`define GRC_MODE_MAX 3'h6
`define GRC_MODE_MAN 3'h3
`define GRC_MODE_NQ 3'h4
`define GRC_MODE_QMAX 3'h2
`define GRC_MODE_VOLT 3'h0
`define GRC_MODE_MIX 3'h1
`define GRC_MODE_SOC 3'h2
`define GRC_PROGRAM_SELECT_USER 3'h4
`define GRC_CFG_GEN 2'h2
`define GRC_STOPV_LO 8'h6e
`define GRC_STOPV_HI 8'ha5
`define GRC_STARTP_LO 8'h00
`define GRC_STARTP_HI 8'h63
`define GRC_STOPP_LO 8'h01
`define GRC_STOPP_HI 8'h7d
`define GRC_SOC_HI 8'h7f
`define GRC_DELAY_LO 8'h01
`define GRC_DELAY_HI 8'h0f
`define GRC_DUR_HI 8'h28
`define GRC_EXI_LO 8'h02
`define GRC_EXI_HI 8'h3c
`define GRC_CNT_MAX 8'hff

// time of day
`define GRC_HR_MORNING 5'h09
`define GRC_HR_EVENING 5'h15
`define GRC_MIN_PER_TENTH 8'h06

// run states
`define GRC_S_IDLE 2'h0
`define GRC_S_AUTO 2'h1
`define GRC_S_MAN 2'h2
`define GRC_S_EXER 2'h3

`endif

// ==== hw/grc_dly.v ====
/*
  changeover delay filter: a condition must hold for a number of whole minutes.
  assumes: minute_tick is a one-cycle pulse on hclk; delay_min is at least 1.
*/
`timescale 1ns/1ps
`include "grc_map.vh"

module grc_dly
(
  input wire hclk,
  input wire hresetn,
  input wire enable,
  input wire cond,
  input wire minute_tick,
  input wire [3:0] delay_min,
  output wire done
);

reg [3:0] cnt_r;

// ==========================================================
// minute counter, cleared as soon as the condition drops
// ==========================================================
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
    cnt_r <= 4'h0;
  else if (!enable || !cond)
    cnt_r <= 4'h0;
  else if (minute_tick && (cnt_r < delay_min))
    cnt_r <= cnt_r + 4'h1;
end

assign done = enable && cond && (cnt_r >= delay_min);

endmodule // grc_dly

// ==== verif/grc_monitor.sv ====
/*
  port checker of grc_top: quiet window, reset, relay routing, filtering and bus.
  assumes: bound to grc_top; control writes are tracked from the bus.
*/
`timescale 1ns/1ps
module grc_monitor
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [4:0] tod_hour,
  input wire minute_tick,
  input wire load_term_drive,
  input wire gp_term_drive,
  input wire gen_run_indicator
);
  // =====
  // helper logic
  reg wr_r;
  reg [7:0] wa_r;
  reg [11:0] ctrl_r;
  reg [2:0] calm_r;
  reg [4:0] hour_r;
  wire take = hsel && htrans[1] && hready;
  wire quiet = tod_hour >= 5'h15 || tod_hour < 5'h09;
  wire qmode = ctrl_r[6:4] != 3'h4 || ctrl_r[2:0] <= 3'h2;
  wire tog_q = wr_r && wa_r == 8'h2c && hwdata[0] && quiet;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      ctrl_r <= 12'h000;
      calm_r <= 3'h0;
      hour_r <= 5'h09;
    end
    else
    begin
      wr_r <= take && hwrite;
      wa_r <= haddr[7:0];
      hour_r <= tod_hour;
      if (wr_r && wa_r == 8'h00)
        ctrl_r <= hwdata[11:0];
      // cycles since anything that may move the request
      if (minute_tick || wr_r || tod_hour != hour_r)
        calm_r <= 3'h0;
      else if (calm_r != 3'h7)
        calm_r <= calm_r + 3'h1;
    end
  end
  // =====
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_QUIET_OFF: assert property ((quiet && qmode) [*3] |-> !gen_run_indicator)
    else $error("request during quiet window");
  AST_RESET_OFF: assert property ($rose(hresetn) |-> !gen_run_indicator
    && !load_term_drive && !gp_term_drive)
    else $error("request active after reset");
  AST_LOAD_ROUTE: assert property (gen_run_indicator && $stable(ctrl_r)
    |-> load_term_drive == (ctrl_r[9:8] == 2'h2))
    else $error("load terminal routing wrong");
  AST_GP_ROUTE: assert property (gen_run_indicator && $stable(ctrl_r)
    |-> gp_term_drive == (ctrl_r[11:10] == 2'h2))
    else $error("general terminal routing wrong");
  AST_IDLE_DRIVE: assert property (!gen_run_indicator |-> !load_term_drive && !gp_term_drive)
    else $error("relay driven without request");
  AST_TOG_QUIET: assert property (tog_q |=> $stable(gen_run_indicator) [*3])
    else $error("toggle accepted in quiet window");
  AST_CALM: assert property (calm_r == 3'h7 |-> $stable(gen_run_indicator))
    else $error("request moved without a cause");
  AST_RD_HOLD: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  COV_START: cover property ($rose(gen_run_indicator));
  COV_STOP: cover property ($fell(gen_run_indicator));
  COV_TOG_Q: cover property (tog_q);
endmodule // grc_monitor

bind grc_top grc_monitor u_grc_monitor
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .tod_hour(tod_hour),
  .minute_tick(minute_tick),
  .load_term_drive(load_term_drive),
  .gp_term_drive(gp_term_drive),
  .gen_run_indicator(gen_run_indicator)
);

// ==== verif/grc_gen_model.sv ====
/*
  generator behind the start relay: runs its own start-up once a run level is seen.
  assumes: either relay terminal may carry the level; crank counts hclk cycles.
*/
`timescale 1ns/1ps
module grc_gen_model
#(
  parameter CRANK = 2
)
(
  input wire hclk,
  input wire hresetn,
  input wire load_term_drive,
  input wire gp_term_drive,
  output reg gen_running
);
  integer crank_r;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crank_r <= 0;
      gen_running <= 1'b0;
    end
    else if (load_term_drive || gp_term_drive)
    begin
      // cranking is ours; the relay only holds a level
      if (crank_r < CRANK)
        crank_r <= crank_r + 1;
      gen_running <= crank_r >= CRANK;
    end
    else
    begin
      crank_r <= 0;
      gen_running <= 1'b0;
    end
  end
endmodule // grc_gen_model

// ==== verif/grc_bench.sv ====
/*
  testbench of grc_top: registers, voltage, charge, manual and exercise runs.
  assumes: bench drives tod_hour and minute_tick; one slave on the bus.
*/
`timescale 1ns/1ps
module grc_bench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg [7:0] batt_volt = 8'h80;
  reg [4:0] tod_hour = 5'h0c;
  reg minute_tick = 1'b0;
  wire hready, hreadyout, hresp, load_term_drive, gp_term_drive, gen_run_indicator, gen_running;
  wire [31:0] hrdata;
  integer errors = 0;
  integer check_count = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  grc_top u_grc_top
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .batt_volt(batt_volt),
    .tod_hour(tod_hour), .minute_tick(minute_tick), .load_term_drive(load_term_drive),
    .gp_term_drive(gp_term_drive), .gen_run_indicator(gen_run_indicator)
  );
  grc_gen_model u_grc_gen_model
  (
    .hclk(hclk), .hresetn(hresetn), .load_term_drive(load_term_drive),
    .gp_term_drive(gp_term_drive), .gen_running(gen_running)
  );
  // =====
  // tasks
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge hclk);
      end
      if (n >= 20)
      begin
        errors = errors + 1;
        final_report;
      end
    end
  endtask
  task bus(input w_en, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      haddr <= {24'h0, a};
      hwrite <= w_en;
      htrans <= 2'h2;
      hsel <= 1'b1;
      rdy;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rdy;
      q = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), q, e);
    end
  endtask
  task wrd(input [7:0] a, input [31:0] d, input [31:0] e);
    begin
      wr(a, d);
      rd(a, e);
    end
  endtask
  task tick(input integer n);
    repeat (n)
    begin
      minute_tick <= 1'b1;
      @(posedge hclk);
      minute_tick <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task hr(input [4:0] h);
    begin
      tod_hour <= h;
      w(2);
    end
  endtask
  task ind(input e);
    begin
      w(4);
      chk("indicator", {31'h0, gen_run_indicator}, {31'h0, e});
    end
  endtask
  // =====
  // sequence
  initial
  begin
    w(3);
    hresetn <= 1'b1;
    w(1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h76);
    rd(8'h08, 32'h8c);
    rd(8'h0c, 32'h32);
    rd(8'h10, 32'h5f);
    rd(8'h14, 32'ha);
    rd(8'h18, 32'ha);
    rd(8'h1c, 32'h7);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h28, 32'h64);
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h40, 32'h0);
    $display("reset values done");
    wrd(8'h08, 32'h6d, 32'h8c);
    wrd(8'h08, 32'ha6, 32'h8c);
    wrd(8'h08, 32'h6e, 32'h6e);
    wrd(8'h08, 32'ha5, 32'ha5);
    wrd(8'h08, 32'h8c, 32'h8c);
    wrd(8'h0c, 32'h64, 32'h32);
    wrd(8'h0c, 32'h0, 32'h0);
    wrd(8'h0c, 32'h63, 32'h63);
    wrd(8'h0c, 32'h32, 32'h32);
    wrd(8'h10, 32'h0, 32'h5f);
    wrd(8'h10, 32'h7e, 32'h5f);
    wrd(8'h10, 32'h1, 32'h1);
    wrd(8'h10, 32'h7d, 32'h7d);
    wrd(8'h10, 32'h5f, 32'h5f);
    wrd(8'h28, 32'h7f, 32'h7f);
    wrd(8'h28, 32'h80, 32'h7f);
    wrd(8'h14, 32'h0, 32'ha);
    wrd(8'h14, 32'h3, 32'h3);
    $display("ranges done");
    wr(8'h00, 32'h200);
    batt_volt <= 8'h76;
    tick(2);
    ind(0);
    batt_volt <= 8'h77;
    tick(1);
    batt_volt <= 8'h76;
    tick(2);
    ind(0);
    tick(1);
    ind(1);
    chk("load drive", load_term_drive, 1);
    chk("gp drive", gp_term_drive, 0);
    w(4);
    chk("generator", gen_running, 1);
    rd(8'h30, 32'h3);
    hr(21);
    ind(0);
    wr(8'h00, 32'h840);
    wrd(8'h00, 32'h844, 32'h844);
    wrd(8'h00, 32'h847, 32'h844);
    tick(3);
    ind(1);
    chk("gp drive", gp_term_drive, 1);
    wr(8'h2c, 32'h1);
    ind(1);
    batt_volt <= 8'h8c;
    tick(2);
    ind(1);
    tick(1);
    ind(0);
    rd(8'h24, 32'h0);
    $display("voltage modes done");
    hr(12);
    batt_volt <= 8'h80;
    wr(8'h00, 32'h845);
    wr(8'h28, 32'h33);
    ind(0);
    wr(8'h28, 32'h32);
    ind(1);
    wr(8'h00, 32'h846);
    wr(8'h28, 32'h5e);
    ind(1);
    wr(8'h28, 32'h5f);
    ind(0);
    wrd(8'h2c, 32'h2, 32'h0);
    rd(8'h28, 32'h64);
    $display("charge modes done");
    wr(8'h00, 32'h843);
    wr(8'h18, 32'h1);
    wr(8'h2c, 32'h1);
    ind(1);
    tick(5);
    ind(1);
    rd(8'h24, 32'h5);
    tick(1);
    ind(0);
    rd(8'h24, 32'h0);
    wr(8'h20, 32'h6);
    hr(8);
    hr(9);
    ind(0);
    rd(8'h20, 32'h7);
    $display("manual mode done");
    wr(8'h00, 32'h844);
    wr(8'h20, 32'h6);
    hr(8);
    hr(9);
    ind(1);
    rd(8'h20, 32'h0);
    rd(8'h30, 32'h7);
    wr(8'h2c, 32'h1);
    ind(1);
    tick(2);
    rd(8'h24, 32'h2);
    wrd(8'h24, 32'h5, 32'h5);
    tick(1);
    ind(0);
    rd(8'h24, 32'h0);
    $display("exercise done");
    final_report;
  end
  initial
  begin
    w(100000);
    errors = errors + 1;
    final_report;
  end
endmodule // grc_bench
